// *** src/bct_pkg.sv ***
`default_nettype none
package bct_pkg;
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
  localparam int unsigned PWM_PERIOD_NS  = 50_000;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_NS;

  localparam int CNT_W = 24;
  localparam int ACC_W = 16;
  localparam int PWM_W = 16;
  localparam int ST_W  = 6;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_GTRIG   = 8'h04;
  localparam logic [7:0] OFF_CAPCFG  = 8'h08;
  localparam logic [7:0] OFF_ACCEPT  = 8'h0C;
  localparam logic [7:0] OFF_PRESC   = 8'h10;
  localparam logic [7:0] OFF_OUTCTRL = 8'h14;
  localparam logic [7:0] OFF_OUTDUTY = 8'h18;
  localparam logic [7:0] OFF_REFCMP  = 8'h1C;
  localparam logic [7:0] OFF_DELAY   = 8'h20;
  localparam logic [7:0] OFF_STATUS  = 8'h24;
  localparam logic [7:0] OFF_MASK    = 8'h28;
  localparam logic [7:0] OFF_STATE   = 8'h2C;
  localparam logic [1:0] CAP_PAGE    = 2'h1;
  localparam logic [1:0] CAP_DUTY    = 2'h0;
  localparam logic [1:0] CAP_PERIOD  = 2'h1;
  localparam logic [1:0] CAP_EDGE_COUNTER    = 2'h2;

  localparam int CTRL_EVAL_EN = 0;
  localparam int CTRL_IE_LSB  = 1;
  localparam int CTRL_SRC     = 4;
  localparam int CTRL_TRG_LSB = 5;
  localparam int CTRL_REN_LSB = 7;
  localparam int CTRL_ROE_LSB = 9;
  localparam int CC_EN        = 0;
  localparam int CC_POL       = 1;
  localparam int CC_SHADOW    = 2;
  localparam int CC_SEL0_LSB  = 3;
  localparam int CC_SEL1_LSB  = 5;
  localparam int CC_FILT      = 7;
  localparam int ST_NEWPAT    = 0;
  localparam int ST_UPDATE    = 1;
  localparam int ST_ZC_LSB    = 2;
  localparam int ST_REFTRIG   = 5;

  localparam logic [7:0]       CAPCFG_RST     = 8'hFB;
  localparam logic [7:0]       PRESC_RST      = 8'h13;
  localparam logic [ACC_W-1:0] ACCEPT_RST     = 16'h0032;
  localparam logic [PWM_W-1:0] REF_PERIOD_RST = PWM_W'(PWM_PERIOD_CYC);
  localparam logic [PWM_W-1:0] REF_DUTY_RST   = PWM_W'(PWM_PERIOD_CYC / 2);

  localparam logic [1:0] SEL_PWM    = 2'h3;
  localparam logic [1:0] TRIG_DELAY = 2'h3;
  localparam logic [1:0] DRV_LOW    = 2'h0;
  localparam logic [1:0] DRV_HIGH   = 2'h1;
  localparam logic [1:0] DRV_PWM    = 2'h2;

  // six-step table, two bits per output {c_lo,c_hi,b_lo,b_hi,a_lo,a_hi}
  function automatic logic [11:0] step_pattern(input logic [2:0] code);
    unique case (code)
      3'h5:    step_pattern = 12'h042;
      3'h4:    step_pattern = 12'h402;
      3'h6:    step_pattern = 12'h420;
      3'h2:    step_pattern = 12'h024;
      3'h3:    step_pattern = 12'h204;
      3'h1:    step_pattern = 12'h240;
      default: step_pattern = 12'h000;
    endcase
  endfunction : step_pattern
endpackage : bct_pkg
`default_nettype wire

// *** src/bct_cap_if.sv ***
`default_nettype none
interface bct_cap_if;
  logic                         en;
  logic                         pol;
  logic                         shadow_sel;
  logic                         filt_en;
  logic [1:0]                   sel0;
  logic [1:0]                   sel1;
  logic [bct_pkg::ACC_W-1:0]    accept;
  logic                         tick;
  logic                         f_out;
  logic                         rise;
  logic [bct_pkg::CNT_W-1:0]    duty;
  logic [bct_pkg::CNT_W-1:0]    period;
  logic [7:0]                   edge_counter;
  modport ctl (output en, pol, shadow_sel, filt_en, sel0, sel1, accept, tick,
               input f_out, rise, duty, period, edge_counter);
  modport chan (input en, pol, shadow_sel, filt_en, sel0, sel1, accept, tick,
                output f_out, rise, duty, period, edge_counter);
endinterface : bct_cap_if
`default_nettype wire

// *** src/bct_capture.sv ***
`default_nettype none
module bct_capture (
  input wire logic  clock,
  input wire logic  rst,
  input wire logic  level,
  bct_cap_if.chan   cap
);
  logic                       in_lvl;
  logic                       f_r;
  logic                       hold_r;
  logic                       rise_r;
  logic [bct_pkg::ACC_W-1:0]  acc_r;
  logic [bct_pkg::CNT_W-1:0]  cnt_r;
  logic [bct_pkg::CNT_W-1:0]  shadow_r;
  logic [bct_pkg::CNT_W-1:0]  duty_r;
  logic [bct_pkg::CNT_W-1:0]  period_r;
  logic [7:0]                 edge_counter_r;
  logic                       accept;
  logic                       rise;
  logic                       fall;

  assign in_lvl = level ^ ~cap.pol;
  // immediate propagation: an edge is taken the cycle it is seen
  assign accept = cap.en && (in_lvl != f_r) && !(cap.filt_en && hold_r);
  assign rise   = accept && in_lvl;
  assign fall   = accept && !in_lvl;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      f_r    <= 1'b0;
      hold_r <= 1'b0;
      acc_r  <= '0;
    end else if (!cap.en) begin
      f_r    <= 1'b0;
      hold_r <= 1'b0;
    end else if (accept) begin
      f_r    <= in_lvl;
      hold_r <= cap.filt_en && (cap.accept != '0);
      acc_r  <= '0;
    end else if (hold_r && cap.tick) begin
      if (acc_r == cap.accept - 16'h1) hold_r <= 1'b0;
      acc_r <= acc_r + 16'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) cnt_r <= '0;
    else if (!cap.en) cnt_r <= '0;
    // the tick on the rise edge already belongs to the new period
    else if (rise) cnt_r <= cap.tick ? 24'h1 : 24'h0;
    else if (cap.tick) cnt_r <= cnt_r + 24'h1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) shadow_r <= '0;
    else if (fall && !cap.shadow_sel) shadow_r <= cnt_r;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      duty_r   <= '0;
      period_r <= '0;
      edge_counter_r   <= '0;
      rise_r   <= 1'b0;
    end else begin
      rise_r <= rise;
      if (rise && cap.sel0 == bct_pkg::SEL_PWM) duty_r <= shadow_r;
      if (rise && cap.sel1 == bct_pkg::SEL_PWM) period_r <= cnt_r;
      if (accept) edge_counter_r <= edge_counter_r + 8'h1;
    end
  end

  assign cap.f_out  = f_r;
  assign cap.rise   = rise_r;
  assign cap.duty   = duty_r;
  assign cap.period = period_r;
  assign cap.edge_counter   = edge_counter_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_duty_result: assert property (rise && cap.sel0 == 2'h3 |=> duty_r == $past(shadow_r))
    else $error("duty result not taken from shadow");
  a_period_result: assert property (rise && cap.sel1 == 2'h3 |=> period_r == $past(cnt_r))
    else $error("period result not taken from counter");
  a_filter_hold: assert property (cap.en && cap.filt_en && hold_r |=> f_r == $past(f_r))
    else $error("filtered level moved during acceptance time");
  a_edge_pass: assert property (cap.en && !hold_r && in_lvl != f_r |=> f_r == $past(in_lvl))
    else $error("edge not propagated at once");
endmodule : bct_capture
`default_nettype wire

// *** src/bct_refpwm.sv ***
`default_nettype none
module bct_refpwm #(
  parameter int W = 16
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         enable,
  input  wire logic         out_enable,
  input  wire logic         start,
  input  wire logic [W-1:0] period_cmp,
  input  wire logic [W-1:0] duty_cmp,
  output logic              level,
  output logic              trig
);
  logic         run_r;
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  assign cnt_nxt = cnt_r + W'(1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) run_r <= 1'b0;
    else if (!enable) run_r <= 1'b0;
    else if (start) run_r <= 1'b1;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      trig  <= 1'b0;
      level <= 1'b0;
    end else if (!run_r) begin
      cnt_r <= '0;
      trig  <= 1'b0;
      level <= 1'b0;
    end else begin
      trig  <= cnt_nxt == period_cmp;
      cnt_r <= (cnt_nxt == period_cmp) ? '0 : cnt_nxt;
      // edge aligned, each period opens high
      level <= out_enable && (cnt_r < duty_cmp);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_ref_wrap: assert property (run_r && enable && cnt_nxt == period_cmp |=> cnt_r == '0 && trig)
    else $error("reference counter did not wrap on period compare");
  a_ref_open: assert property (run_r && enable && out_enable && cnt_r == '0 && duty_cmp != '0
                               |=> level)
    else $error("reference period did not start high");
endmodule : bct_refpwm
`default_nettype wire

// *** src/bct_top.sv ***
// Contract
// - polarity one measures high time, starts on rise
// - count to falling edge, copy to shadow
// - next rise: shadow to duty, count to period
// - edge counter bits one to seven readable (code reads all eight bits, zero to seven)
// - filter passes both edges immediately
// - after edge ignore input for acceptance time
// - evaluator drives six outputs plus delay channel
// - new pattern restarts delay; second edge updates outputs
// - reference channels edge aligned, half duty, start high
// - reference counter resets on period compare
// - global trigger starts both references together
// - one reference triggers ADC, other resets outputs
//
// The address map and register access over APB are this design's own decisions.
`default_nettype none
module bct_top (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  zc_in,
  output logic      [5:0]  pwm_out,
  output logic             delay_out,
  output logic             adc_trig,
  output logic             ref_sync,
  output logic             irq
);
  localparam int PW = bct_pkg::PWM_W;

  logic [10:0]                ctrl_r;
  logic [7:0]                 capcfg_r;
  logic [bct_pkg::ACC_W-1:0]  accept_r;
  logic [7:0]                 presc_r;
  logic [11:0]                outctrl_r;
  logic [PW-1:0]              outduty_r;
  logic [PW-1:0]              ref_per_r;
  logic [PW-1:0]              ref_duty_r;
  logic [PW-1:0]              dcm0_r;
  logic [PW-1:0]              dcm1_r;
  logic [bct_pkg::ST_W-1:0]   status_r;
  logic [bct_pkg::ST_W-1:0]   mask_r;
  logic                       gtrig_r;
  logic [2:0]                 zc_s1_r;
  logic [2:0]                 zc_s2_r;
  logic [7:0]                 presc_cnt_r;
  logic                       tick_r;
  logic [2:0]                 code_r;
  logic [2:0]                 code_w;
  logic                       newpat;
  logic                       dly_run_r;
  logic [PW-1:0]              dly_cnt_r;
  logic                       upd;
  logic [11:0]                pattern_r;
  logic [PW-1:0]              out_cnt_r;
  logic                       pwm_src_r;
  logic [1:0]                 ref_lvl;
  logic [1:0]                 ref_trig;
  logic [2:0]                 f_lvl;
  logic [2:0]                 zc_ev;
  logic [bct_pkg::CNT_W-1:0]  duty_a [3];
  logic [bct_pkg::CNT_W-1:0]  period_a [3];
  logic [7:0]                 edge_counter_a [3];
  logic                       access;
  logic                       wr;
  logic [31:0]                rd_val;
  logic                       rd_err;
  logic [1:0]                 ch;

  assign access = psel && penable && pready;
  assign wr     = access && pwrite && !rd_err;
  assign ch     = paddr[5:4];

  // one wait state so read data can come from a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_val;
      pslverr <= psel && penable && !pready && rd_err;
    end
  end

  always_comb begin
    rd_val = '0;
    rd_err = 1'b0;
    if (paddr[7:6] == bct_pkg::CAP_PAGE) begin
      if (ch == 2'h3 || paddr[1:0] != 2'h0) rd_err = 1'b1;
      else begin
        unique case (paddr[3:2])
          bct_pkg::CAP_DUTY:   rd_val = {8'h00, duty_a[ch]};
          bct_pkg::CAP_PERIOD: rd_val = {8'h00, period_a[ch]};
          bct_pkg::CAP_EDGE_COUNTER:   rd_val = {24'h000000, edge_counter_a[ch]};
          default:             rd_err = 1'b1;
        endcase
      end
    end else begin
      unique case (paddr)
        bct_pkg::OFF_CTRL:    rd_val = {21'h000000, ctrl_r};
        bct_pkg::OFF_GTRIG:   rd_val = '0;
        bct_pkg::OFF_CAPCFG:  rd_val = {24'h000000, capcfg_r};
        bct_pkg::OFF_ACCEPT:  rd_val = {16'h0000, accept_r};
        bct_pkg::OFF_PRESC:   rd_val = {24'h000000, presc_r};
        bct_pkg::OFF_OUTCTRL: rd_val = {20'h00000, outctrl_r};
        bct_pkg::OFF_OUTDUTY: rd_val = {16'h0000, outduty_r};
        bct_pkg::OFF_REFCMP:  rd_val = {ref_duty_r, ref_per_r};
        bct_pkg::OFF_DELAY:   rd_val = {dcm0_r, dcm1_r};
        bct_pkg::OFF_STATUS:  rd_val = {26'h0000000, status_r};
        bct_pkg::OFF_MASK:    rd_val = {26'h0000000, mask_r};
        bct_pkg::OFF_STATE:   rd_val = {20'h00000, pattern_r[5:0], dly_run_r, code_r, f_lvl[1:0]};
        default:              rd_err = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r     <= '0;
      capcfg_r   <= bct_pkg::CAPCFG_RST;
      accept_r   <= bct_pkg::ACCEPT_RST;
      presc_r    <= bct_pkg::PRESC_RST;
      outctrl_r  <= '0;
      outduty_r  <= '0;
      ref_per_r  <= bct_pkg::REF_PERIOD_RST;
      ref_duty_r <= bct_pkg::REF_DUTY_RST;
      dcm0_r     <= '0;
      dcm1_r     <= '0;
      mask_r     <= '0;
    end else if (wr) begin
      unique case (paddr)
        bct_pkg::OFF_CTRL:    ctrl_r <= pwdata[10:0];
        bct_pkg::OFF_CAPCFG:  capcfg_r <= pwdata[7:0];
        bct_pkg::OFF_ACCEPT:  accept_r <= pwdata[15:0];
        bct_pkg::OFF_PRESC:   presc_r <= pwdata[7:0];
        bct_pkg::OFF_OUTCTRL: outctrl_r <= pwdata[11:0];
        bct_pkg::OFF_OUTDUTY: outduty_r <= pwdata[15:0];
        bct_pkg::OFF_REFCMP: begin
          ref_per_r  <= pwdata[15:0];
          ref_duty_r <= pwdata[31:16];
        end
        bct_pkg::OFF_DELAY: begin
          dcm1_r <= pwdata[15:0];
          dcm0_r <= pwdata[31:16];
        end
        bct_pkg::OFF_MASK:    mask_r <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) gtrig_r <= 1'b0;
    else gtrig_r <= wr && paddr == bct_pkg::OFF_GTRIG && pwdata[0];
  end

  // zero-cross levels come from another block's pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      zc_s1_r <= '0;
      zc_s2_r <= '0;
    end else begin
      zc_s1_r <= zc_in;
      zc_s2_r <= zc_s1_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      presc_cnt_r <= '0;
      tick_r      <= 1'b0;
    end else begin
      tick_r      <= presc_cnt_r == presc_r;
      presc_cnt_r <= (presc_cnt_r >= presc_r) ? 8'h00 : presc_cnt_r + 8'h01;
    end
  end

  bct_cap_if cif[3] ();

  for (genvar g = 0; g < 3; g++) begin : g_cap
    assign cif[g].en         = capcfg_r[bct_pkg::CC_EN];
    assign cif[g].pol        = capcfg_r[bct_pkg::CC_POL];
    assign cif[g].shadow_sel = capcfg_r[bct_pkg::CC_SHADOW];
    assign cif[g].sel0       = capcfg_r[bct_pkg::CC_SEL0_LSB +: 2];
    assign cif[g].sel1       = capcfg_r[bct_pkg::CC_SEL1_LSB +: 2];
    assign cif[g].filt_en    = capcfg_r[bct_pkg::CC_FILT];
    assign cif[g].accept     = accept_r;
    assign cif[g].tick       = tick_r;
    assign f_lvl[g]          = cif[g].f_out;
    assign zc_ev[g]          = cif[g].rise;
    assign duty_a[g]         = cif[g].duty;
    assign period_a[g]       = cif[g].period;
    assign edge_counter_a[g]         = cif[g].edge_counter;
    bct_capture u_cap (
      .clock (clock),
      .rst   (rst),
      .level (zc_s2_r[g]),
      .cap   (cif[g])
    );
  end

  assign code_w = f_lvl & ctrl_r[bct_pkg::CTRL_IE_LSB +: 3];
  assign newpat = ctrl_r[bct_pkg::CTRL_EVAL_EN] && code_w != code_r;
  // delay channel: one-shot, first compare drops level, second one updates
  assign upd = ctrl_r[bct_pkg::CTRL_TRG_LSB +: 2] == bct_pkg::TRIG_DELAY
               ? dly_run_r && dly_cnt_r + 16'h1 == dcm0_r : newpat;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      code_r    <= '0;
      dly_run_r <= 1'b0;
      dly_cnt_r <= '0;
      delay_out <= 1'b0;
    end else if (newpat) begin
      code_r    <= code_w;
      dly_run_r <= 1'b1;
      dly_cnt_r <= '0;
      delay_out <= 1'b1;
    end else if (dly_run_r) begin
      dly_cnt_r <= dly_cnt_r + 16'h1;
      if (dly_cnt_r + 16'h1 == dcm1_r) delay_out <= 1'b0;
      if (dly_cnt_r + 16'h1 == dcm0_r) begin
        dly_run_r <= 1'b0;
        delay_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) pattern_r <= '0;
    else if (!ctrl_r[bct_pkg::CTRL_EVAL_EN]) pattern_r <= outctrl_r;
    else if (upd) pattern_r <= bct_pkg::step_pattern(newpat ? code_w : code_r);
  end

  bct_refpwm #(.W(PW)) u_ref_adc (
    .clock      (clock),
    .rst        (rst),
    .enable     (ctrl_r[bct_pkg::CTRL_REN_LSB]),
    .out_enable (ctrl_r[bct_pkg::CTRL_ROE_LSB]),
    .start      (gtrig_r),
    .period_cmp (ref_per_r),
    .duty_cmp   (ref_duty_r),
    .level      (ref_lvl[0]),
    .trig       (ref_trig[0])
  );

  bct_refpwm #(.W(PW)) u_ref_sync (
    .clock      (clock),
    .rst        (rst),
    .enable     (ctrl_r[bct_pkg::CTRL_REN_LSB + 1]),
    .out_enable (ctrl_r[bct_pkg::CTRL_ROE_LSB + 1]),
    .start      (gtrig_r),
    .period_cmp (ref_per_r),
    .duty_cmp   (ref_duty_r),
    .level      (ref_lvl[1]),
    .trig       (ref_trig[1])
  );

  // output counter restarts on the sync reference wrap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_cnt_r <= '0;
      pwm_src_r <= 1'b0;
    end else begin
      out_cnt_r <= ref_trig[1] ? '0 : out_cnt_r + 16'h1;
      pwm_src_r <= out_cnt_r < outduty_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_out  <= '0;
      adc_trig <= 1'b0;
      ref_sync <= 1'b0;
    end else begin
      adc_trig <= ref_lvl[0];
      ref_sync <= ref_lvl[1];
      for (int i = 0; i < 6; i++) begin
        unique case (pattern_r[2*i +: 2])
          bct_pkg::DRV_LOW:  pwm_out[i] <= 1'b0;
          bct_pkg::DRV_HIGH: pwm_out[i] <= 1'b1;
          bct_pkg::DRV_PWM:  pwm_out[i] <= pwm_src_r;
          default:           pwm_out[i] <= !pwm_src_r;
        endcase
      end
    end
  end

  // set wins over a simultaneous write-one clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_r <= '0;
      irq      <= 1'b0;
    end else begin
      status_r <= (status_r & ~((wr && paddr == bct_pkg::OFF_STATUS) ? pwdata[5:0] : 6'h00))
                  | {ref_trig[0], zc_ev, upd, newpat};
      irq      <= |(status_r & mask_r);
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_new_pattern: assert property (newpat |=> dly_run_r && dly_cnt_r == '0 && delay_out)
    else $error("new pattern did not restart delay channel");
  a_pattern_update: assert property (upd && ctrl_r[0] && !newpat
                                     |=> pattern_r == bct_pkg::step_pattern($past(code_r)))
    else $error("output pattern not updated from input code");
  a_manual_pattern: assert property (!ctrl_r[0] |=> pattern_r == $past(outctrl_r))
    else $error("manual pattern not applied while evaluator off");
  a_out_reset: assert property (ref_trig[1] |=> out_cnt_r == '0
                                ##1 (out_cnt_r == 16'h0001 || $past(ref_trig[1])))
    else $error("output counter not reset by sync reference");
  a_irq_level: assert property (|(status_r & mask_r) |=> irq)
    else $error("interrupt not raised for unmasked status");
endmodule : bct_top
`default_nettype wire

// *** verif/bct_zc_model.sv ***
`default_nettype none
module bct_zc_model #(
  parameter int HI = 6,
  parameter int LO = 10
) (
  input  wire logic       clock,
  input  wire logic       run,
  input  wire logic [2:0] code,
  output logic      [2:0] zc
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt_r;
  // phase 0 turns periodic while run; the others hold static hall-like levels
  always_ff @(posedge clock) begin
    if (!run || cnt_r == HI + LO - 1) begin
      cnt_r <= 0;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  assign zc = run ? {code[2:1], cnt_r < HI} : code;
endmodule : bct_zc_model
`default_nettype wire

// *** verif/bct_top_tb.sv ***
`default_nettype none
module bct_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]  RA [6] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h30};
  localparam logic [31:0] RV [6] = '{32'h0, 32'hFB, 32'h32, 32'h13, 32'h01F403E8, 32'h0};
  localparam logic [2:0]  CODES [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  localparam logic [11:0] PATS [6] = '{12'h042, 12'h402, 12'h420, 12'h024, 12'h204, 12'h240};
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, er, run;
  logic        delay_out, adc_trig, ref_sync, irq;
  logic [2:0]  zc_in, code;
  logic [5:0]  pwm_out;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, e1;
  int          num_errors, total_checks, n, hcnt, diff;

  bct_zc_model #(.HI(6), .LO(10)) i_zc (.clock(clock), .run(run), .code(code), .zc(zc_in));
  bct_top i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zc_in(zc_in), .pwm_out(pwm_out), .delay_out(delay_out), .adc_trig(adc_trig),
    .ref_sync(ref_sync), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      num_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      results();
    end
  endtask : bound

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // entered just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    bound(k, 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    run = 1'b0;
    code = 3'h0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, RA[i], 32'h0);
      chk(rd, RV[i]);
      chk(32'(er), 32'(RA[i] == 8'h30));
    end
    $display("test reset values done");
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h08, 32'h7B);
    apb(1'b1, 8'h28, 32'h4);
    run <= 1'b1;
    repeat (60) @(posedge clock);
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h6);
    apb(1'b0, 8'h44, 32'h0);
    chk(rd, 32'h10);
    apb(1'b0, 8'h54, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h48, 32'h0);
    e1 = rd;
    repeat (12) @(posedge clock);
    apb(1'b0, 8'h48, 32'h0);
    chk((rd - e1) & 32'hFF, 32'h2);
    chk(32'(irq), 32'h1);
    $display("test capture done");
    apb(1'b1, 8'h0C, 32'h30);
    apb(1'b1, 8'h08, 32'hFB);
    apb(1'b0, 8'h48, 32'h0);
    e1 = rd;
    repeat (60) @(posedge clock);
    apb(1'b0, 8'h48, 32'h0);
    chk(32'(((rd - e1) & 32'hFF) <= 32'h3), 32'h1);
    run <= 1'b0;
    apb(1'b1, 8'h08, 32'h7B);
    apb(1'b1, 8'h24, 32'hFF);
    repeat (3) @(posedge clock);
    chk(32'(irq), 32'h0);
    $display("test filter and irq done");
    apb(1'b1, 8'h28, 32'h0);
    apb(1'b1, 8'h14, 32'h555);
    repeat (2) @(posedge clock);
    chk(32'(pwm_out), 32'h3F);
    apb(1'b1, 8'h00, 32'h0F);
    for (int i = 0; i < 6; i++) begin
      code <= CODES[i];
      repeat (8) @(posedge clock);
      for (int j = 0; j < 6; j++)
        chk(32'(pwm_out[j]), 32'(PATS[i][2*j+:2] == 2'h1));
    end
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h20, 32'h00280014);
    apb(1'b1, 8'h00, 32'h6F);
    code <= 3'h4;
    repeat (10) @(posedge clock);
    chk({30'h0, pwm_out[5], delay_out}, 32'h1);
    repeat (50) @(posedge clock);
    chk(32'(pwm_out[5]), 32'h1);
    $display("test evaluator done");
    apb(1'b1, 8'h1C, 32'h000A0014);
    apb(1'b1, 8'h00, 32'h780);
    apb(1'b1, 8'h04, 32'h1);
    n = 0;
    while (adc_trig !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    bound(n, 50);
    hcnt = 0;
    diff = 0;
    repeat (20) begin
      @(posedge clock);
      hcnt += int'(adc_trig === 1'b1);
      diff += int'(adc_trig !== ref_sync);
    end
    chk(32'(hcnt), 32'hA);
    chk(32'(diff), 32'h0);
    $display("test reference pwm done");
    results();
  end
endmodule : bct_top_tb
`default_nettype wire
